// [hdl/ext_mem_bus.sv]
// External memory bus engine: static, I/O, DRAM and SDRAM access sequencing
// What this block does
// - Drive a 22-bit word address covering 4M words per bank.
// - Split a 23-bit internal address into DRAM row and column.
// - Column bit count, one setting shared by all DRAM banks, selectable from 8 to 11.
// - Raise address bit 10 with SDRAM read/write when auto precharge wanted.
// - Data bus serves 8, 16 and 32 bit devices.
// - Four active-low row strobes, doubling as SDRAM bank selects.
// - Column strobes mark selected byte lanes during DRAM access.
// - SDRAM row address presented with SDRAM row strobe low.
// - SDRAM column address presented with SDRAM column strobe low.
// - Dropping clock enable freezes SDRAM from next cycle, for power down.
// - Clock enable raised at least one cycle before any SDRAM command.
// - DRAM writes use own write enable; static banks use byte enables.
// - Four I/O banks of 16 KB, one select asserted per access.
// - Wait input from I/O or static bank 5 stretches the access.
// - SDRAM clock out runs in phase with the system clock.
`default_nettype none
module ext_mem_bus (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // Static configuration
  input wire logic I_SDRAM_MODE,
  input wire logic [1:0] I_DRAM_BANK_CONFIG,
  input wire logic I_SDRAM_POWER_DOWN,
  // Access request
  input wire logic I_REQ_VALID,
  input wire logic I_REQ_WRITE,
  input wire logic [1:0] I_REQ_KIND,
  input wire logic [2:0] I_REQ_BANK,
  input wire logic [22:0] I_REQ_ADDRESS,
  input wire logic [3:0] I_REQ_BYTE_EN,
  input wire logic [1:0] I_REQ_WIDTH,
  input wire logic [31:0] I_REQ_WDATA,
  input wire logic [2:0] I_REQ_WAIT_CYCLES,
  input wire logic I_REQ_AUTO_PRECHARGE,
  output logic O_REQ_READY,
  // Access answer
  output logic O_ACK,
  output logic [31:0] O_RD_DATA,
  // External memory pins
  output logic [21:0] O_MEM_ADDRESS,
  output logic [31:0] O_EXT_DATA_BUS_OUT,
  output logic O_EXT_DATA_BUS_OE,
  input wire logic [31:0] I_EXT_DATA_BUS_IN,
  output logic [3:0] O_DRAM_ROW_STROBE_N,
  output logic [3:0] O_DRAM_COL_STROBE_N,
  output logic O_DRAM_WRITE_ENABLE_N,
  output logic [3:0] O_BYTE_WRITE_ENABLE_N,
  output logic O_OUTPUT_ENABLE_N,
  output logic [3:0] O_IO_BANK_SELECT_N,
  input wire logic I_EXT_WAIT_N,
  output logic O_SDRAM_CLOCK_OUT
);
  // ------------------------------------------------------------
  // State record
  // ------------------------------------------------------------
  typedef struct packed {
    ext_mem_pkg::state_type st;
    logic [3:0] cnt;
    logic [1:0] kind;
    logic [2:0] bank;
    logic write;
    logic [3:0] lanes;
    logic [1:0] width;
    logic [2:0] cycles;
    logic ap;
    logic waitable;
    logic [21:0] row;
    logic [21:0] col;
    logic [21:0] addr;
    logic [31:0] wdata;
    logic data_oe;
    logic [3:0] row_n;
    logic [3:0] col_n;
    logic sd_ras_n;
    logic sd_cas_n;
    logic cke;
    logic dwe_n;
    logic [3:0] wbe_n;
    logic oe_n;
    logic [3:0] ecs_n;
    logic [31:0] rdata;
    logic ack;
  } eng_state_type;

  eng_state_type eng_reg;
  eng_state_type eng_next;
  sync_if wait_link ();

  logic accept;
  logic [3:0] col_shift;
  logic [22:0] col_mask;
  logic [3:0] lane_sel;
  logic [31:0] rd_masked;

  // ------------------------------------------------------------
  // Wait pin synchroniser
  // ------------------------------------------------------------
  wait_sync wait_sync_inst (
    .i_clock (I_CLOCK),
    .i_reset_n (I_RESET_N),
    .i_async_n (I_EXT_WAIT_N),
    .o_sync (wait_link.src)
  );

  // Request decode: column split and lane selection
  always_comb begin
    col_shift = ext_mem_pkg::COL_BITS_MIN + {2'h0, I_DRAM_BANK_CONFIG};
    col_mask = ~(23'h7FFFFF << col_shift);
    case (I_REQ_WIDTH)
      ext_mem_pkg::WIDTH_8: lane_sel = I_REQ_BYTE_EN & 4'h1;
      ext_mem_pkg::WIDTH_16: lane_sel = I_REQ_BYTE_EN & 4'h3;
      default: lane_sel = I_REQ_BYTE_EN;
    endcase
  end

  // Narrow devices return data on the low lanes only
  always_comb begin
    case (eng_reg.width)
      ext_mem_pkg::WIDTH_8: rd_masked = {24'h000000, I_EXT_DATA_BUS_IN[7:0]};
      ext_mem_pkg::WIDTH_16: rd_masked = {16'h0000, I_EXT_DATA_BUS_IN[15:0]};
      default: rd_masked = I_EXT_DATA_BUS_IN;
    endcase
  end

  assign accept = I_REQ_VALID && (eng_reg.st == ext_mem_pkg::S_IDLE);

  // ------------------------------------------------------------
  // Transitions, then pin values for the state being entered
  // ------------------------------------------------------------
  always_comb begin
    eng_next = eng_reg;
    case (eng_reg.st)
      ext_mem_pkg::S_IDLE: begin
        if (accept) begin
          eng_next.kind = I_REQ_KIND;
          eng_next.bank = I_REQ_BANK;
          eng_next.write = I_REQ_WRITE;
          eng_next.lanes = lane_sel;
          eng_next.width = I_REQ_WIDTH;
          eng_next.cycles = I_REQ_WAIT_CYCLES;
          eng_next.ap = I_REQ_AUTO_PRECHARGE;
          eng_next.wdata = I_REQ_WDATA;
          eng_next.waitable = (I_REQ_KIND == ext_mem_pkg::KIND_IO) ||
            ((I_REQ_KIND != ext_mem_pkg::KIND_DRAM) && (I_REQ_BANK == ext_mem_pkg::WAIT_BANK));
          eng_next.row = 22'(I_REQ_ADDRESS >> col_shift);
          eng_next.col = 22'(I_REQ_ADDRESS & col_mask);
          eng_next.addr = I_REQ_ADDRESS[21:0];
          if (I_REQ_KIND == ext_mem_pkg::KIND_DRAM) begin
            if (!I_SDRAM_MODE) begin
              eng_next.st = ext_mem_pkg::S_DRAM_ROW;
              eng_next.cnt = ext_mem_pkg::DRAM_ROW_CYCLES - 4'h1;
            end else if (eng_reg.cke) begin
              eng_next.st = ext_mem_pkg::S_SD_ACT;
            end else begin
              eng_next.st = ext_mem_pkg::S_WAKE;
            end
          end else begin
            eng_next.st = ext_mem_pkg::S_STATIC;
            eng_next.cnt = {1'b0, I_REQ_WAIT_CYCLES};
          end
        end
      end
      ext_mem_pkg::S_WAKE: eng_next.st = ext_mem_pkg::S_SD_ACT;
      ext_mem_pkg::S_DRAM_ROW: begin
        if (eng_reg.cnt == 4'h0) begin
          eng_next.st = ext_mem_pkg::S_DRAM_COL;
          eng_next.cnt = {1'b0, eng_reg.cycles};
        end else begin
          eng_next.cnt = eng_reg.cnt - 4'h1;
        end
      end
      ext_mem_pkg::S_DRAM_COL: begin
        if (eng_reg.cnt == 4'h0) begin
          eng_next.st = ext_mem_pkg::S_DONE;
          if (!eng_reg.write) begin
            eng_next.rdata = rd_masked;
          end
        end else begin
          eng_next.cnt = eng_reg.cnt - 4'h1;
        end
      end
      ext_mem_pkg::S_SD_ACT: eng_next.st = ext_mem_pkg::S_SD_CMD;
      ext_mem_pkg::S_SD_CMD: begin
        eng_next.st = ext_mem_pkg::S_SD_LAT;
        eng_next.cnt = eng_reg.write ? 4'h0 : ext_mem_pkg::SDRAM_CAS_LATENCY - 4'h1;
      end
      ext_mem_pkg::S_SD_LAT: begin
        if (eng_reg.cnt == 4'h0) begin
          eng_next.st = eng_reg.ap ? ext_mem_pkg::S_DONE : ext_mem_pkg::S_SD_PRE;
          if (!eng_reg.write) begin
            eng_next.rdata = rd_masked;
          end
        end else begin
          eng_next.cnt = eng_reg.cnt - 4'h1;
        end
      end
      ext_mem_pkg::S_SD_PRE: eng_next.st = ext_mem_pkg::S_DONE;
      ext_mem_pkg::S_STATIC, ext_mem_pkg::S_STRETCH: begin
        // Wait is only honoured after the programmed count has run out
        if ((eng_reg.st == ext_mem_pkg::S_STATIC) && (eng_reg.cnt != 4'h0)) begin
          eng_next.cnt = eng_reg.cnt - 4'h1;
        end else if (eng_reg.waitable && !wait_link.wait_n) begin
          eng_next.st = ext_mem_pkg::S_STRETCH;
        end else begin
          eng_next.st = ext_mem_pkg::S_DONE;
          if (!eng_reg.write) begin
            eng_next.rdata = rd_masked;
          end
        end
      end
      ext_mem_pkg::S_DONE: eng_next.st = ext_mem_pkg::S_IDLE;
      default: eng_next.st = ext_mem_pkg::S_IDLE;
    endcase

    // Every strobe and enable starts idle, clock enable high, and is pulled active by the entered state only; address and write data keep their value
    eng_next.ack = (eng_next.st == ext_mem_pkg::S_DONE);
    eng_next.data_oe = 1'b0;
    eng_next.row_n = ext_mem_pkg::STROBES_IDLE;
    eng_next.col_n = ext_mem_pkg::STROBES_IDLE;
    eng_next.sd_ras_n = 1'b1;
    eng_next.sd_cas_n = 1'b1;
    eng_next.dwe_n = 1'b1;
    eng_next.wbe_n = ext_mem_pkg::STROBES_IDLE;
    eng_next.oe_n = 1'b1;
    eng_next.ecs_n = ext_mem_pkg::STROBES_IDLE;
    eng_next.cke = 1'b1;
    case (eng_next.st)
      ext_mem_pkg::S_IDLE, ext_mem_pkg::S_DONE: begin
        eng_next.cke = !I_SDRAM_POWER_DOWN;
      end
      ext_mem_pkg::S_DRAM_ROW: begin
        eng_next.addr = eng_next.row;
        eng_next.row_n[eng_next.bank[1:0]] = 1'b0;
        eng_next.data_oe = eng_next.write;
      end
      ext_mem_pkg::S_DRAM_COL: begin
        eng_next.addr = eng_next.col;
        eng_next.row_n[eng_next.bank[1:0]] = 1'b0;
        eng_next.col_n = ~eng_next.lanes;
        eng_next.dwe_n = !eng_next.write;
        eng_next.oe_n = eng_next.write;
        eng_next.data_oe = eng_next.write;
      end
      ext_mem_pkg::S_SD_ACT: begin
        eng_next.addr = eng_next.row;
        eng_next.row_n[eng_next.bank[1:0]] = 1'b0;
        eng_next.sd_ras_n = 1'b0;
      end
      ext_mem_pkg::S_SD_CMD: begin
        eng_next.addr = eng_next.col;
        eng_next.addr[ext_mem_pkg::AP_BIT] = eng_next.ap;
        eng_next.row_n[eng_next.bank[1:0]] = 1'b0;
        eng_next.sd_cas_n = 1'b0;
        eng_next.dwe_n = !eng_next.write;
        eng_next.wbe_n = ~eng_next.lanes; // Byte mask during SDRAM data
        eng_next.data_oe = eng_next.write;
      end
      ext_mem_pkg::S_SD_LAT: begin
        eng_next.wbe_n = ~eng_next.lanes;
        eng_next.oe_n = eng_next.write;
      end
      ext_mem_pkg::S_SD_PRE: begin
        eng_next.addr[ext_mem_pkg::AP_BIT] = 1'b1; // Close every bank
        eng_next.row_n[eng_next.bank[1:0]] = 1'b0;
        eng_next.sd_ras_n = 1'b0;
        eng_next.dwe_n = 1'b0;
      end
      ext_mem_pkg::S_STATIC, ext_mem_pkg::S_STRETCH: begin
        if (eng_next.write) begin
          eng_next.wbe_n = ~eng_next.lanes;
        end
        eng_next.oe_n = eng_next.write;
        eng_next.data_oe = eng_next.write;
        if (eng_next.kind == ext_mem_pkg::KIND_IO) begin
          eng_next.ecs_n[eng_next.bank[1:0]] = 1'b0;
        end
      end
      default: eng_next.cke = 1'b1; // Wake holds clock enable high
    endcase
  end

  // State register
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      eng_reg <= '0;
      eng_reg.st <= ext_mem_pkg::S_IDLE;
      eng_reg.row_n <= ext_mem_pkg::STROBES_IDLE;
      eng_reg.col_n <= ext_mem_pkg::STROBES_IDLE;
      eng_reg.sd_ras_n <= 1'b1;
      eng_reg.sd_cas_n <= 1'b1;
      eng_reg.dwe_n <= 1'b1;
      eng_reg.wbe_n <= ext_mem_pkg::STROBES_IDLE;
      eng_reg.oe_n <= 1'b1;
      eng_reg.ecs_n <= ext_mem_pkg::STROBES_IDLE;
      eng_reg.cke <= ext_mem_pkg::CKE_RESET;
    end else begin
      eng_reg <= eng_next;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Shared column pins carry the SDRAM strobes and clock enable in SDRAM mode
  assign O_DRAM_COL_STROBE_N = I_SDRAM_MODE ?
    {1'b1, eng_reg.cke, eng_reg.sd_cas_n, eng_reg.sd_ras_n} : eng_reg.col_n;
  // Forwarded clock: no gating so the memory sees the same phase as this logic
  assign O_SDRAM_CLOCK_OUT = I_CLOCK;
  assign O_REQ_READY = (eng_reg.st == ext_mem_pkg::S_IDLE);
  assign O_ACK = eng_reg.ack;
  assign O_RD_DATA = eng_reg.rdata;
  assign O_MEM_ADDRESS = eng_reg.addr;
  assign O_EXT_DATA_BUS_OUT = eng_reg.wdata;
  assign O_EXT_DATA_BUS_OE = eng_reg.data_oe;
  assign O_DRAM_ROW_STROBE_N = eng_reg.row_n;
  assign O_DRAM_WRITE_ENABLE_N = eng_reg.dwe_n;
  assign O_BYTE_WRITE_ENABLE_N = eng_reg.wbe_n;
  assign O_OUTPUT_ENABLE_N = eng_reg.oe_n;
  assign O_IO_BANK_SELECT_N = eng_reg.ecs_n;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);

  sequence sd_activate;
    (eng_reg.st == ext_mem_pkg::S_SD_ACT) && !eng_reg.sd_ras_n && eng_reg.addr == eng_reg.row;
  endsequence
  sequence sd_column;
    !eng_reg.sd_cas_n && eng_reg.sd_ras_n && eng_reg.addr[9:0] == eng_reg.col[9:0];
  endsequence

  sd_row_col_a: assert property (sd_activate |=> sd_column)
    else $error("SDRAM column command did not follow activate");
  ap_bit_a: assert property (!eng_reg.sd_cas_n |-> eng_reg.addr[10] == eng_reg.ap)
    else $error("auto precharge bit wrong at column command");
  cke_lead_a: assert property ((!eng_reg.sd_ras_n || !eng_reg.sd_cas_n) |->
    $past(eng_reg.cke) && eng_reg.cke)
    else $error("SDRAM command without clock enable lead");
  power_down_a: assert property ((O_REQ_READY && !I_REQ_VALID && I_SDRAM_POWER_DOWN)
    |=> !eng_reg.cke)
    else $error("clock enable not dropped for power down");
  io_select_a: assert property ((eng_reg.ecs_n != 4'hF) |->
    $onehot(~eng_reg.ecs_n) && !eng_reg.ecs_n[eng_reg.bank[1:0]] &&
    eng_reg.kind == ext_mem_pkg::KIND_IO)
    else $error("I/O bank select does not match bank");
  dram_lanes_a: assert property ((eng_reg.st == ext_mem_pkg::S_DRAM_COL) |->
    O_DRAM_COL_STROBE_N == ~eng_reg.lanes && !eng_reg.row_n[eng_reg.bank[1:0]])
    else $error("column strobes disagree with byte lanes");
  col_width_a: assert property ((eng_reg.st == ext_mem_pkg::S_DRAM_COL) |->
    (eng_reg.addr >> (ext_mem_pkg::COL_BITS_MIN + {2'h0, I_DRAM_BANK_CONFIG})) == 22'h0)
    else $error("column address wider than configured");
  write_split_a: assert property (!I_SDRAM_MODE |->
    !((O_BYTE_WRITE_ENABLE_N != 4'hF) && !O_DRAM_WRITE_ENABLE_N))
    else $error("DRAM and static write enables both active");
  stretch_hold_a: assert property ((eng_reg.st == ext_mem_pkg::S_STRETCH &&
    !wait_link.wait_n) |=> eng_reg.st == ext_mem_pkg::S_STRETCH [*1] ##0 !O_ACK)
    else $error("access ended while wait asserted");
  static_len_a: assert property ((eng_reg.st == ext_mem_pkg::S_IDLE && accept &&
    I_REQ_KIND == ext_mem_pkg::KIND_STATIC && I_REQ_BANK != ext_mem_pkg::WAIT_BANK &&
    I_REQ_WAIT_CYCLES == 3'h0) |=> ##1 O_ACK)
    else $error("unstretched static access took wrong length");
endmodule : ext_mem_bus
`default_nettype wire

// [hdl/ext_mem_pkg.sv]
// Shared constants and types of the external memory bus interface
`default_nettype none
package ext_mem_pkg;
  // ------------------------------------------------------------
  // Bus widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int INT_ADDR_W = 23;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int AP_BIT = 10;

  // ------------------------------------------------------------
  // Request kinds, bus widths and address split
  // ------------------------------------------------------------
  localparam logic [1:0] KIND_STATIC = 2'h0;
  localparam logic [1:0] KIND_IO = 2'h1;
  localparam logic [1:0] KIND_DRAM = 2'h2;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;
  localparam logic [3:0] COL_BITS_MIN = 4'h8;
  localparam logic [2:0] WAIT_BANK = 3'h5;
  localparam int IO_BANK_BYTES = 16384;

  // ------------------------------------------------------------
  // Cycle counts and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] DRAM_ROW_CYCLES = 4'h1;
  localparam logic [3:0] SDRAM_CAS_LATENCY = 4'h2;
  localparam logic [3:0] STROBES_IDLE = 4'hF;
  localparam logic CKE_RESET = 1'b0;
  localparam logic WAIT_N_RESET = 1'b1;

  // ------------------------------------------------------------
  // Access state machine
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_WAKE = 4'h1,
    S_DRAM_ROW = 4'h2,
    S_DRAM_COL = 4'h3,
    S_SD_ACT = 4'h4,
    S_SD_CMD = 4'h5,
    S_SD_LAT = 4'h6,
    S_SD_PRE = 4'h7,
    S_STATIC = 4'h8,
    S_STRETCH = 4'h9,
    S_DONE = 4'hA
  } state_type;
endpackage : ext_mem_pkg
`default_nettype wire

// [hdl/sync_if.sv]
// Carrier between the wait synchroniser and the access engine
`default_nettype none
interface sync_if;
  logic wait_n;
  modport src (output wait_n);
  modport dst (input wait_n);
endinterface : sync_if
`default_nettype wire

// [hdl/wait_sync.sv]
// Three-stage synchroniser with agreement filter for the external wait pin
`default_nettype none
module wait_sync (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Raw pin
  input wire logic i_async_n,
  // Filtered level
  sync_if.src o_sync
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_type;

  sync_state_type sync_reg;
  sync_state_type sync_next;

  // Only the second stage reads the first; the level moves once s2 and s3 agree
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = i_async_n;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    if (sync_reg.s2 == sync_reg.s3) begin
      sync_next.level = sync_reg.s3;
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_reg <= '{s1: ext_mem_pkg::WAIT_N_RESET, s2: ext_mem_pkg::WAIT_N_RESET,
                    s3: ext_mem_pkg::WAIT_N_RESET, level: ext_mem_pkg::WAIT_N_RESET};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_sync.wait_n = sync_reg.level;

  // Filtered level only changes to a value both later stages held
  level_agree_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    $changed(sync_reg.level) |-> ($past(sync_reg.s2) == $past(sync_reg.s3)))
    else $error("wait level moved without stage agreement");
endmodule : wait_sync
`default_nettype wire

// [test/ext_dev_model.sv]
// Behavioural external memory and I/O device standing on the far side of the bus
`default_nettype none
module ext_dev_model (
  // Clock
  input wire logic i_clock,
  // Pins from the bus engine
  input wire logic i_oe_n,
  input wire logic [21:0] i_addr,
  // Wait request from the bench
  input wire logic i_wait_go,
  input wire logic [7:0] i_wait_len,
  // Pins to the bus engine
  output logic [31:0] o_data,
  output logic o_wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg = 8'h00;
  logic [31:0] idle_reg = 32'h0000_0000;
  // Released bus moves every cycle so a stale word can never pass as read data
  assign o_data = i_oe_n ? idle_reg : {10'h2A5, i_addr} ^ 32'h5A5A_C3C3;
  // Wait counts down and lets go only on a rising clock edge
  always_ff @(posedge i_clock) begin
    idle_reg <= ~idle_reg ^ {24'h000000, cnt_reg};
    if (i_wait_go) begin
      cnt_reg <= i_wait_len;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  assign o_wait_n = (cnt_reg == 8'h00);
endmodule : ext_dev_model
`default_nettype wire

// [test/external_memory_bus_interface_bench.sv]
// Self-checking bench of the external memory bus engine
`default_nettype none
module external_memory_bus_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, sd_mode, pwr_dn, valid, wr, ap, wgo, ready, ack, doe, dwe_n, oe_n, sdram_clock_out;
  logic wait_n;
  logic [1:0] cfg, kind, wid;
  logic [2:0] bank, wc;
  logic [22:0] addr;
  logic [3:0] be, row_n, col_n, wbe_n, ios_n;
  logic [31:0] wdata, mdata, bus_in, rdata, dout;
  logic [21:0] maddr;
  logic [7:0] wlen;
  logic [21:0] sa[40];
  logic [3:0] sr[40], sc[40], sw[40], se[40];
  logic sdw[40], sdo[40];
  logic [31:0] sd[40];
  logic [15:0] seed = 16'h001E;
  int n_fail = 0;
  int checked = 0;
  int ackc, i, k;
  // Wire level of the shared data bus
  assign bus_in = doe ? dout : mdata;

  ext_mem_bus dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_SDRAM_MODE(sd_mode),
    .I_DRAM_BANK_CONFIG(cfg), .I_SDRAM_POWER_DOWN(pwr_dn), .I_REQ_VALID(valid),
    .I_REQ_WRITE(wr), .I_REQ_KIND(kind), .I_REQ_BANK(bank), .I_REQ_ADDRESS(addr),
    .I_REQ_BYTE_EN(be), .I_REQ_WIDTH(wid), .I_REQ_WDATA(wdata), .I_REQ_WAIT_CYCLES(wc),
    .I_REQ_AUTO_PRECHARGE(ap), .O_REQ_READY(ready), .O_ACK(ack), .O_RD_DATA(rdata),
    .O_MEM_ADDRESS(maddr), .O_EXT_DATA_BUS_OUT(dout), .O_EXT_DATA_BUS_OE(doe),
    .I_EXT_DATA_BUS_IN(bus_in), .O_DRAM_ROW_STROBE_N(row_n), .O_DRAM_COL_STROBE_N(col_n),
    .O_DRAM_WRITE_ENABLE_N(dwe_n), .O_BYTE_WRITE_ENABLE_N(wbe_n), .O_OUTPUT_ENABLE_N(oe_n),
    .O_IO_BANK_SELECT_N(ios_n), .I_EXT_WAIT_N(wait_n), .O_SDRAM_CLOCK_OUT(sdram_clock_out));
  ext_dev_model mdl (.i_clock(sdram_clock_out), .i_oe_n(oe_n), .i_addr(maddr), .i_wait_go(wgo),
    .i_wait_len(wlen), .o_data(mdata), .o_wait_n(wait_n));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Narrow devices use the low lanes only
  function automatic logic [3:0] lanes(input logic [3:0] b, input logic [1:0] w);
    return w == ext_mem_pkg::WIDTH_8 ? b & 4'h1 : w == ext_mem_pkg::WIDTH_16 ? b & 4'h3 : b;
  endfunction : lanes
  function automatic logic [31:0] exp_rd(input logic [21:0] a, input logic [1:0] w);
    logic [31:0] v;
    v = {10'h2A5, a} ^ 32'h5A5A_C3C3;
    return w == ext_mem_pkg::WIDTH_8 ? v & 32'h0000_00FF :
      w == ext_mem_pkg::WIDTH_16 ? v & 32'h0000_FFFF : v;
  endfunction : exp_rd
  // One access: pins are snapshotted each cycle after the taking edge
  task automatic run(input logic [1:0] k_in, input logic w, input logic [2:0] b,
    input logic p, input logic [2:0] c);
    @(posedge clk);
    #2;
    chk("ready", ready, 1'b1);
    kind = k_in;
    wr = w;
    bank = b;
    ap = p;
    wc = c;
    valid = 1'b1;
    ackc = 0;
    for (i = 1; i < 40 && ackc == 0; i++) begin
      @(posedge clk);
      #1;
      sa[i] = maddr;
      sr[i] = row_n;
      sc[i] = col_n;
      sw[i] = wbe_n;
      se[i] = ios_n;
      sdw[i] = dwe_n;
      sdo[i] = doe;
      sd[i] = dout;
      if (ack === 1'b1) ackc = i;
      #1;
      valid = 1'b0;
    end
  endtask : run
  task automatic roll;
    seed = lfsr(seed);
    addr = {seed[6:0], lfsr(seed)};
    be = seed[11:8] | 4'h1;
    wid = seed[13:12] == 2'h0 ? ext_mem_pkg::WIDTH_32 : seed[13:12];
    wdata = {seed, lfsr(seed)};
  endtask : roll
  task automatic pulse_wait;
    @(posedge clk);
    #2;
    wgo = 1'b1;
    @(posedge clk);
    #2;
    wgo = 1'b0;
  endtask : pulse_wait
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A few hundred cycles are expected; this bound is far beyond that
  initial begin
    #100us;
    n_fail++;
    stop_test;
  end
  initial begin
    {rst_n, sd_mode, pwr_dn, valid, wr, ap, wgo, cfg, kind, bank, wc} = '0;
    {addr, be, wdata} = '0;
    wid = ext_mem_pkg::WIDTH_32;
    wlen = 8'h0C;
    repeat (12) @(posedge clk);
    chk("idle row", row_n, 4'hF);
    chk("idle io", ios_n, 4'hF);
    #2;
    rst_n = 1'b1;
    $display("test reset done");
    for (k = 0; k < 6; k++) begin
      roll;
      run(ext_mem_pkg::KIND_STATIC, 1'b0, seed[2:0] == 3'h5 ? 3'h4 : seed[2:0], 1'b0, seed[5:3]);
      chk("st addr", sa[1], addr[21:0]);
      chk("st ack", ackc, 2 + wc);
      chk("st data", rdata, exp_rd(addr[21:0], wid));
    end
    for (k = 0; k < 4; k++) begin
      roll;
      run(ext_mem_pkg::KIND_IO, 1'b1, 3'(k), 1'b0, seed[5:3]);
      chk("io sel", se[1], 4'(~(4'h1 << k)));
      chk("io wbe", sw[1], 4'(~lanes(be, wid)));
      chk("io oe", sdo[1], 1'b1);
      chk("io data", sd[1], wdata);
    end
    $display("test static done");
    for (k = 0; k < 4; k++) begin
      roll;
      cfg = 2'(k);
      run(ext_mem_pkg::KIND_DRAM, 1'b1, 3'(k), 1'b0, 3'h0);
      chk("dr row", sr[1], 4'(~(4'h1 << k)));
      chk("dr raddr", sa[1], addr >> (8 + k));
      chk("dr caddr", sa[2], addr & ((23'h1 << (8 + k)) - 23'h1));
      chk("dr cas", sc[2], 4'(~lanes(be, wid)));
      chk("dr we", {sdw[2], sw[2], ackc[3:0]}, {1'b0, 4'hF, 4'h3});
    end
    $display("test dram done");
    wlen = 8'h0C;
    pulse_wait;
    // Four programmed cycles leave the synchroniser time to show wait before the count ends
    run(ext_mem_pkg::KIND_IO, 1'b0, 3'h2, 1'b0, 3'h4);
    chk("io stretch", ackc > 8, 1'b1);
    pulse_wait;
    run(ext_mem_pkg::KIND_STATIC, 1'b0, 3'h5, 1'b0, 3'h4);
    chk("b5 stretch", ackc > 8, 1'b1);
    pulse_wait;
    run(ext_mem_pkg::KIND_STATIC, 1'b0, 3'h3, 1'b0, 3'h4);
    chk("b3 no wait", ackc, 6);
    repeat (16) @(posedge clk);
    $display("test wait done");
    sd_mode = 1'b1;
    cfg = 2'h0;
    for (k = 0; k < 3; k++) begin
      roll;
      run(ext_mem_pkg::KIND_DRAM, k == 2, 3'(k), k != 1, 3'h0);
      chk("sd cs", sr[1], 4'(~(4'h1 << k)));
      chk("sd ras", {sc[1][0], sa[1]}, {1'b0, 22'(addr >> 8)});
      chk("sd cas", {sc[2][1:0], sa[2][7:0]}, {2'b01, addr[7:0]});
      chk("sd ap", sa[2][10], k != 1);
      chk("sd ack", ackc, k == 0 ? 5 : k == 1 ? 6 : 4);
    end
    pwr_dn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("cke low", col_n[2], 1'b0);
    chk("sdram_clock_out", sdram_clock_out, clk);
    run(ext_mem_pkg::KIND_DRAM, 1'b0, 3'h1, 1'b1, 3'h0);
    chk("wake", {sc[1][2], sr[1], sr[2]}, {1'b1, 4'hF, 4'hD});
    chk("wake ack", ackc, 6);
    pwr_dn = 1'b0;
    #12;
    chk("sdram_clock_out lo", sdram_clock_out, clk);
    $display("test sdram done");
    stop_test;
  end
endmodule : external_memory_bus_interface_bench
`default_nettype wire
